// ---- clear_compare_decrement_alu.sv ----
// Register-driven executor for the clear, invert, compare and decrement group
//
// Notes on behaviour
// - Wipe accumulator: accumulator zero, zero flag set
// - Wipe file cell: cell zero, zero flag set
// - Kick clears watchdog, prescaler if assigned there
// - Kick sets expired and power-down flags only
// - Invert complements cell, zero flag from result
// - Target 0 to accumulator, 1 to cell
// - Compare subtracts accumulator from cell, sets flags
// - Compare changes neither accumulator nor cell
// - Decrement cell to target, zero flag from result
`timescale 1ns/1ps
`default_nettype none

module clear_compare_decrement_alu (
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] accum;
        logic [alu_pkg::CELL_COUNT-1:0][7:0] cells;
        logic zero_flag;
        logic carry_flag;
        logic watchdog_expired_flag;
        logic power_down_flag;
        logic [7:0] watchdog_counter;
        logic [7:0] shared_prescaler;
        logic presc_to_wdt;
        logic [5:0] cell_addr;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    logic [2:0] cmd_op;
    logic cmd_target;
    logic [5:0] cmd_addr;
    logic [7:0] alu_result;
    logic alu_wr_accum;
    logic alu_wr_cell;
    logic alu_upd_zero;
    logic alu_zero;
    logic alu_upd_carry;
    logic alu_carry;
    logic alu_kick;
    logic setup_phase;
    logic access_done;
    logic exec;

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr == alu_pkg::OFS_COMMAND) || (addr == alu_pkg::OFS_ACCUM) ||
                 (addr == alu_pkg::OFS_STATUS) || (addr == alu_pkg::OFS_WATCHDOG) ||
                 (addr == alu_pkg::OFS_CONTROL) || (addr == alu_pkg::OFS_CELL_ADDR) ||
                 (addr == alu_pkg::OFS_CELL_DATA);
    endfunction

    // ------------------------------------------------------------------
    // Command decode and datapath
    // ------------------------------------------------------------------
    // Command register holds no state: a write fires the operation at once
    assign cmd_op = pwdata_in[alu_pkg::CMD_OP_LSB +: 3];
    assign cmd_target = pwdata_in[alu_pkg::CMD_TARGET_BIT];
    assign cmd_addr = pwdata_in[alu_pkg::CMD_ADDR_LSB +: alu_pkg::CELL_AW];
    assign setup_phase = psel_in && !penable_in;
    assign access_done = psel_in && penable_in && state_r.ready;
    assign exec = access_done && pwrite_in && (paddr_in == alu_pkg::OFS_COMMAND);

    cell_alu u_alu (
        .op_in(cmd_op),
        .target_in(cmd_target),
        .accum_in(state_r.accum),
        .cell_in(state_r.cells[cmd_addr]),
        .result_out(alu_result),
        .write_accum_out(alu_wr_accum),
        .write_cell_out(alu_wr_cell),
        .update_zero_out(alu_upd_zero),
        .zero_out(alu_zero),
        .update_carry_out(alu_upd_carry),
        .carry_out(alu_carry),
        .kick_out(alu_kick)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;

        // Free-running watchdog; nothing here acts on a timeout
        if (state_r.presc_to_wdt) begin
            state_nxt.shared_prescaler = state_r.shared_prescaler + alu_pkg::BYTE_ONE;
            if (state_r.shared_prescaler == 8'hFF) begin
                state_nxt.watchdog_counter = state_r.watchdog_counter + alu_pkg::BYTE_ONE;
            end
        end else begin
            state_nxt.watchdog_counter = state_r.watchdog_counter + alu_pkg::BYTE_ONE;
        end

        // Answer in the first access cycle; read data caught in setup
        // Read data stands for the answer cycle only, writes answer zero
        state_nxt.ready = setup_phase;
        state_nxt.slverr = setup_phase && !mapped(paddr_in);
        state_nxt.rdata = 32'h0000_0000;
        if (setup_phase && !pwrite_in) begin
            case (paddr_in)
                alu_pkg::OFS_ACCUM: begin
                    state_nxt.rdata[7:0] = state_r.accum;
                end
                alu_pkg::OFS_STATUS: begin
                    state_nxt.rdata[alu_pkg::ST_ZERO_BIT] = state_r.zero_flag;
                    state_nxt.rdata[alu_pkg::ST_CARRY_BIT] = state_r.carry_flag;
                    state_nxt.rdata[alu_pkg::ST_EXPIRED_BIT] = state_r.watchdog_expired_flag;
                    state_nxt.rdata[alu_pkg::ST_POWER_DOWN_BIT] = state_r.power_down_flag;
                end
                alu_pkg::OFS_WATCHDOG: begin
                    state_nxt.rdata[7:0] = state_r.watchdog_counter;
                    state_nxt.rdata[alu_pkg::WDG_PRESC_LSB +: 8] = state_r.shared_prescaler;
                end
                alu_pkg::OFS_CONTROL: begin
                    state_nxt.rdata[alu_pkg::CTL_PRESC_WDT_BIT] = state_r.presc_to_wdt;
                end
                alu_pkg::OFS_CELL_ADDR: begin
                    state_nxt.rdata[5:0] = state_r.cell_addr;
                end
                alu_pkg::OFS_CELL_DATA: begin
                    state_nxt.rdata[7:0] = state_r.cells[state_r.cell_addr];
                end
                default: begin
                    state_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Plain register writes
        if (access_done && pwrite_in) begin
            case (paddr_in)
                alu_pkg::OFS_ACCUM: begin
                    state_nxt.accum = pwdata_in[7:0];
                end
                alu_pkg::OFS_STATUS: begin
                    state_nxt.zero_flag = pwdata_in[alu_pkg::ST_ZERO_BIT];
                    state_nxt.carry_flag = pwdata_in[alu_pkg::ST_CARRY_BIT];
                    state_nxt.watchdog_expired_flag = pwdata_in[alu_pkg::ST_EXPIRED_BIT];
                    state_nxt.power_down_flag = pwdata_in[alu_pkg::ST_POWER_DOWN_BIT];
                end
                alu_pkg::OFS_CONTROL: begin
                    state_nxt.presc_to_wdt = pwdata_in[alu_pkg::CTL_PRESC_WDT_BIT];
                end
                alu_pkg::OFS_CELL_ADDR: begin
                    state_nxt.cell_addr = pwdata_in[5:0];
                end
                alu_pkg::OFS_CELL_DATA: begin
                    state_nxt.cells[state_r.cell_addr] = pwdata_in[7:0];
                end
                default: begin
                    state_nxt.accum = state_r.accum;
                end
            endcase
        end

        // Instruction execution, completed in the write's own cycle
        if (exec) begin
            if (alu_wr_accum) begin
                state_nxt.accum = alu_result;
            end
            if (alu_wr_cell) begin
                state_nxt.cells[cmd_addr] = alu_result;
            end
            if (alu_upd_zero) begin
                state_nxt.zero_flag = alu_zero;
            end
            if (alu_upd_carry) begin
                state_nxt.carry_flag = alu_carry;
            end
            if (alu_kick) begin
                state_nxt.watchdog_counter = alu_pkg::BYTE_ZERO;
                if (state_r.presc_to_wdt) begin
                    state_nxt.shared_prescaler = alu_pkg::BYTE_ZERO;
                end
                state_nxt.watchdog_expired_flag = 1'b1;
                state_nxt.power_down_flag = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_r <= '0;
            state_r.zero_flag <= alu_pkg::RST_ZERO_FLAG;
            state_r.carry_flag <= alu_pkg::RST_CARRY_FLAG;
            state_r.watchdog_expired_flag <= alu_pkg::RST_EXPIRED_FLAG;
            state_r.power_down_flag <= alu_pkg::RST_POWER_DOWN_FLAG;
            state_r.presc_to_wdt <= alu_pkg::RST_PRESC_WDT;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign prdata_out = state_r.rdata;
    assign pready_out = state_r.ready;
    assign pslverr_out = state_r.slverr;
endmodule

`default_nettype wire

// ---- cell_alu.sv ----
// Package of shared constants and the combinational instruction datapath
`timescale 1ns/1ps
`default_nettype none

package alu_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    localparam logic [7:0] OFS_ACCUM = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_WATCHDOG = 8'h0C;
    localparam logic [7:0] OFS_CONTROL = 8'h10;
    localparam logic [7:0] OFS_CELL_ADDR = 8'h14;
    localparam logic [7:0] OFS_CELL_DATA = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_TARGET_BIT = 3;
    localparam int CMD_ADDR_LSB = 4;
    localparam int ST_ZERO_BIT = 0;
    localparam int ST_CARRY_BIT = 1;
    localparam int ST_EXPIRED_BIT = 2;
    localparam int ST_POWER_DOWN_BIT = 3;
    localparam int CTL_PRESC_WDT_BIT = 0;
    localparam int WDG_PRESC_LSB = 8;

    // ------------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------------
    localparam int CELL_COUNT = 64;
    localparam int CELL_AW = 6;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic RST_ZERO_FLAG = 1'b0;
    localparam logic RST_CARRY_FLAG = 1'b0;
    localparam logic RST_EXPIRED_FLAG = 1'b1;
    localparam logic RST_POWER_DOWN_FLAG = 1'b1;
    localparam logic RST_PRESC_WDT = 1'b1;

    // ------------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_WIPE_ACCUMULATOR = 3'h1,
        OP_WIPE_FILE_CELL = 3'h2,
        OP_KICK_WATCHDOG = 3'h3,
        OP_INVERT_FILE_CELL = 3'h4,
        OP_COMPARE_ACCUMULATOR = 3'h5,
        OP_MINUS_ONE_FILE_CELL = 3'h6
    } op_t;
endpackage

module cell_alu (
    // Operation and operands
    input wire logic [2:0] op_in,
    input wire logic target_in,
    input wire logic [7:0] accum_in,
    input wire logic [7:0] cell_in,
    // Results
    output logic [7:0] result_out,
    output logic write_accum_out,
    output logic write_cell_out,
    output logic update_zero_out,
    output logic zero_out,
    output logic update_carry_out,
    output logic carry_out,
    output logic kick_out
);
    logic [8:0] diff;

    always_comb begin
        diff = {1'b0, cell_in} - {1'b0, accum_in};
        result_out = alu_pkg::BYTE_ZERO;
        write_accum_out = 1'b0;
        write_cell_out = 1'b0;
        update_zero_out = 1'b0;
        zero_out = 1'b0;
        update_carry_out = 1'b0;
        carry_out = 1'b0;
        kick_out = 1'b0;
        case (alu_pkg::op_t'(op_in))
            alu_pkg::OP_WIPE_ACCUMULATOR: begin
                write_accum_out = 1'b1;
                update_zero_out = 1'b1;
                zero_out = 1'b1;
            end
            alu_pkg::OP_WIPE_FILE_CELL: begin
                write_cell_out = 1'b1;
                update_zero_out = 1'b1;
                zero_out = 1'b1;
            end
            alu_pkg::OP_KICK_WATCHDOG: begin
                kick_out = 1'b1;
            end
            alu_pkg::OP_INVERT_FILE_CELL: begin
                result_out = ~cell_in;
                write_accum_out = ~target_in;
                write_cell_out = target_in;
                update_zero_out = 1'b1;
                zero_out = (result_out == alu_pkg::BYTE_ZERO);
            end
            alu_pkg::OP_COMPARE_ACCUMULATOR: begin
                // Difference only feeds the flags, never a destination
                update_zero_out = 1'b1;
                zero_out = (diff[7:0] == alu_pkg::BYTE_ZERO);
                update_carry_out = 1'b1;
                carry_out = ~diff[8];
            end
            alu_pkg::OP_MINUS_ONE_FILE_CELL: begin
                result_out = cell_in - alu_pkg::BYTE_ONE;
                write_accum_out = ~target_in;
                write_cell_out = target_in;
                update_zero_out = 1'b1;
                zero_out = (result_out == alu_pkg::BYTE_ZERO);
            end
            default: begin
                result_out = alu_pkg::BYTE_ZERO;
            end
        endcase
    end
endmodule

`default_nettype wire

// ---- alu_checker.sv ----
// Checker of bus timing and instruction side effects at the top ports
`timescale 1ns/1ps
`default_nettype none
module alu_checker (
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out
);
    // ------------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);
    sequence s_setup;
        psel_in && !penable_in;
    endsequence
    sequence s_exec(logic [2:0] op);
        psel_in && penable_in && pwrite_in && pready_out && paddr_in == alu_pkg::OFS_COMMAND
            && pwdata_in[2:0] == op;
    endsequence
    sequence s_read(logic [7:0] a);
        psel_in && !penable_in && !pwrite_in && paddr_in == a;
    endsequence
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_ready_next;
        s_setup |=> pready_out;
    endproperty
    a_ready_next: assert property (p_ready_next) else $error("ready late");
    property p_ready_pulse;
        pready_out |=> !pready_out;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_ready_cause;
        pready_out |-> $past(psel_in) && !$past(penable_in);
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
    property p_err_ready;
        pslverr_out |-> pready_out;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_idle_data;
        !pready_out |-> prdata_out == 32'h0;
    endproperty
    a_idle_data: assert property (p_idle_data) else $error("read data outside access");
    property p_unmapped;
        psel_in && !penable_in && paddr_in > 8'h18 |=> pslverr_out;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped without error");
    property p_mapped;
        psel_in && !penable_in && paddr_in <= 8'h18 && paddr_in[1:0] == 2'h0 |=> !pslverr_out;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped with error");
    // Kick, then status read at once: both flags must already be set
    property p_kick_flags;
        s_exec(3'h3) ##1 s_read(alu_pkg::OFS_STATUS) |=> prdata_out[3:2] == 2'h3;
    endproperty
    a_kick_flags: assert property (p_kick_flags) else $error("kick flags wrong");
    property p_wipe_acc;
        s_exec(3'h1) ##1 s_read(alu_pkg::OFS_ACCUM) |=> prdata_out[7:0] == 8'h00;
    endproperty
    a_wipe_acc: assert property (p_wipe_acc) else $error("accumulator not wiped");
endmodule
bind clear_compare_decrement_alu alu_checker u_alu_checker (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out)
);
`default_nettype wire

// ---- clear_compare_decrement_alu_tb.sv ----
// Self-checking bench for the clear, invert, compare and decrement executor
`timescale 1ns/1ps
`default_nettype none
module clear_compare_decrement_alu_tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clock_in = 1'b0;
    logic srst_in = 1'b1;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic [31:0] seed = 32'h556E2183;
    logic [31:0] rd;
    int fail_count = 0;
    int n_checks = 0;
    clear_compare_decrement_alu u_clear_compare_decrement_alu (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .psel_in(psel_in),
        .penable_in(penable_in),
        .pwrite_in(pwrite_in),
        .paddr_in(paddr_in),
        .pwdata_in(pwdata_in),
        .prdata_out(prdata_out),
        .pready_out(pready_out),
        .pslverr_out(pslverr_out)
    );
    initial begin
        forever #50 clock_in = ~clock_in;
    end
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Leaves psel up so that the next call is a back-to-back setup
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic err, output logic [31:0] r);
        int n;
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        r = prdata_out;
        chk({31'h0, pready_out}, 32'h1);
        chk({31'h0, pslverr_out}, {31'h0, err});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(a, 1'b1, d, 1'b0, r);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0, 1'b0, rd);
        chk(rd, exp);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        int op, t, a, cl, ac, st, r, z, c, to, pd, ps;
        int mq[$];
        repeat (6) @(posedge clock_in);
        srst_in <= 1'b0;
        rdchk(alu_pkg::OFS_STATUS, 32'hC);
        rdchk(alu_pkg::OFS_CONTROL, 32'h1);
        rdchk(alu_pkg::OFS_COMMAND, 32'h0);
        apb(8'h1C, 1'b0, 32'h0, 1'b1, rd);
        chk(rd, 32'h0);
        apb(8'h80, 1'b1, 32'hFFFFFFFF, 1'b1, rd);
        // Prescaler on the counter: kick must leave it alone
        wr(alu_pkg::OFS_CONTROL, 32'h0);
        apb(alu_pkg::OFS_WATCHDOG, 1'b0, 32'h0, 1'b0, rd);
        ps = rd[15:8];
        wr(alu_pkg::OFS_WATCHDOG, 32'hFFFF);
        wr(alu_pkg::OFS_STATUS, 32'h3);
        wr(alu_pkg::OFS_COMMAND, 32'h3);
        rdchk(alu_pkg::OFS_STATUS, 32'hF);
        apb(alu_pkg::OFS_WATCHDOG, 1'b0, 32'h0, 1'b0, rd);
        chk({24'h0, rd[15:8]}, 32'(ps));
        chk({31'h0, rd[7:0] < 8'h8}, 32'h1);
        // Prescaler on the watchdog: both cleared
        wr(alu_pkg::OFS_CONTROL, 32'h1);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        repeat (600) @(posedge clock_in);
        apb(alu_pkg::OFS_WATCHDOG, 1'b0, 32'h0, 1'b0, rd);
        chk({31'h0, rd[7:0] != 8'h0}, 32'h1);
        wr(alu_pkg::OFS_COMMAND, 32'h3);
        apb(alu_pkg::OFS_WATCHDOG, 1'b0, 32'h0, 1'b0, rd);
        chk({31'h0, rd[7:0] == 8'h0 && rd[15:8] < 8'h8}, 32'h1);
        // Random operands against the integer model, every op code first
        for (int i = 0; i < 200; i++) begin
            seed = xs(seed);
            a = seed[5:0];
            cl = (i % 7 == 0) ? 1 : seed[15:8];
            ac = (i % 5 == 0) ? cl : seed[23:16];
            st = seed[27:24];
            op = (i < 16) ? i % 8 : seed[30:28];
            t = seed[31];
            wr(alu_pkg::OFS_CELL_ADDR, 32'(a));
            wr(alu_pkg::OFS_CELL_DATA, 32'(cl));
            wr(alu_pkg::OFS_ACCUM, 32'(ac));
            wr(alu_pkg::OFS_STATUS, 32'(st));
            wr(alu_pkg::OFS_COMMAND, 32'((a << 4) | (t << 3) | op));
            z = st % 2;
            c = st / 2 % 2;
            to = st / 4 % 2;
            pd = st / 8;
            case (op)
                1: begin
                    ac = 0;
                    z = 1;
                end
                2: begin
                    cl = 0;
                    z = 1;
                end
                3: begin
                    to = 1;
                    pd = 1;
                end
                4, 6: begin
                    r = (op == 4) ? (~cl & 255) : ((cl - 1) & 255);
                    z = (r == 0);
                    if (t == 1) begin
                        cl = r;
                    end else begin
                        ac = r;
                    end
                end
                5: begin
                    z = (((cl - ac) & 255) == 0);
                    c = (cl >= ac);
                end
                default: ;
            endcase
            // Expected accumulator, status and cell, in the order they are read
            mq = '{ac, pd * 8 + to * 4 + c * 2 + z, cl};
            rdchk(alu_pkg::OFS_ACCUM, 32'(mq[0]));
            rdchk(alu_pkg::OFS_STATUS, 32'(mq[1]));
            rdchk(alu_pkg::OFS_CELL_DATA, 32'(mq[2]));
        end
        finish_test();
    end
    // Whole run needs some 4000 cycles
    initial begin
        #2000000;
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
